// >>> rtl/lsrw_addr_adder.sv
// Write address generator for combined read-write datagrams
`timescale 1ns/100ps
module lsrw_addr_adder (
    // Clock and reset
    input wire logic clk_i,
    input wire logic reset_i,
    // Request
    input wire logic valid_i,
    input wire logic [15:0] addr_i,
    input wire logic [15:0] offset_i,
    // Answer
    output logic valid_o,
    output logic [15:0] rd_addr_o,
    output logic [15:0] wr_addr_o
);
    logic [15:0] sum;

    // Wraps modulo 64 Ki like the datagram address space itself
    assign sum = 16'(addr_i + offset_i);

    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            valid_o <= 1'b0;
            rd_addr_o <= 16'h0000;
            wr_addr_o <= 16'h0000;
        end else begin
            valid_o <= valid_i;
            rd_addr_o <= addr_i;
            wr_addr_o <= sum;
        end
    end
endmodule // lsrw_addr_adder

// >>> rtl/lsrw_pkg.sv
// Package for the link status and read-write offset register bank
package lsrw_pkg;
    // Byte addresses of the two registers (low byte at the lower address)
    localparam logic [15:0] RW_OFFSET_ADDR = 16'h0108;
    localparam logic [15:0] LINK_STATUS_ADDR = 16'h0110;
    localparam logic [15:0] RW_OFFSET_RESET = 16'h0000;
    localparam logic [15:0] LINK_STATUS_RESET = 16'h0000;
    // Status field positions
    localparam int COMM_P0_BIT = 9;
    localparam int COMM_P1_BIT = 11;
    localparam int COMM_P2_BIT = 13;
    localparam int LOOP_P0_BIT = 8;
    localparam int LOOP_P1_BIT = 10;
    localparam int LOOP_P2_BIT = 12;
    localparam int LINK_P0_BIT = 4;
    localparam int LINK_P1_BIT = 5;
    localparam int LINK_P2_BIT = 6;
    localparam int ENH_LINK_BIT = 2;
    localparam int WDOG_BIT = 1;
    localparam int LOADED_BIT = 0;
    localparam int NUM_PORTS = 3;

    // Byte-wide access from either side
    typedef struct packed {
        logic        rd;
        logic        wr;
        logic [15:0] addr;
        logic [7:0]  wdata;
    } lsrw_acc_t;

    // Live conditions that feed the status word
    typedef struct packed {
        logic [2:0] comm;
        logic [2:0] loop_closed;
        logic [2:0] link;
        logic       wdog_ok;
    } lsrw_live_t;
endpackage

// >>> rtl/lsrw_regs.sv
// Link status and read-write offset register bank of the slave controller core
`timescale 1ns/100ps
module lsrw_regs (
    // Clock and reset
    input wire logic clk_i,
    input wire logic reset_i,
    // Network-side byte access
    input wire lsrw_pkg::lsrw_acc_t net_acc_i,
    output logic [7:0] net_rdata_o,
    output logic net_rvalid_o,
    // Host process interface byte access
    input wire lsrw_pkg::lsrw_acc_t host_acc_i,
    output logic [7:0] host_rdata_o,
    output logic host_rvalid_o,
    // Live port conditions from pins or other clock domains
    input wire logic [2:0] port_comm_i,
    input wire logic [2:0] port_loop_closed_i,
    input wire logic [2:0] port_link_i,
    input wire logic wdog_reloaded_i,
    // Configuration memory load result, same clock
    input wire logic load_done_i,
    input wire logic load_ok_i,
    input wire logic load_enh_link_i,
    // Event flag interface
    input wire logic link_event_set_i,
    output logic link_event_o,
    // Process data gate for the host side
    output logic host_pd_enable_o,
    // Combined read-write datagram address split
    input wire logic rw_dgram_valid_i,
    input wire logic [15:0] rw_dgram_addr_i,
    output logic rw_dgram_valid_o,
    output logic [15:0] rw_dgram_rd_addr_o,
    output logic [15:0] rw_dgram_wr_addr_o,
    // Register views
    output logic [15:0] rw_offset_o,
    output logic [15:0] link_status_o
);
    // Port timing, counted in clock edges after the cause
    // Byte access taken on the edge that sees rd or wr high
    // Read data and rvalid stand for one clock after that edge, zero otherwise
    // Reads outside the two registers answer zero
    // Host writes, and any write to the status word, vanish without an answer
    // Live pin change reaches the status word five clocks later
    // Those five are three synchroniser stages, the agreement stage and the status flop
    // A one-clock glitch on a pin never reaches the status word, by the agreement stage
    // Load pulse shows in status bit 0 and the host data gate two clocks later
    // Enhanced link bit moves only at the first load after reset
    // Event flag output shows the flag as it stands after the edge that set or cleared it
    // A set on the same edge as the clearing read wins, so no event is lost
    // Datagram split answers one clock after the request
    // Split uses the offset as it stood before any write on that same edge
    // Trade-off: the agreement stage costs a clock of latency but filters pin glitches

    // Raw and synchronised live conditions
    lsrw_pkg::lsrw_live_t live_raw;
    lsrw_pkg::lsrw_live_t live;
    // Offset register
    logic [15:0] rw_offset_q;
    logic [15:0] rw_offset_d;
    // Status word and load state
    logic [15:0] status_d;
    logic enh_link_q;
    logic first_load_seen_q;
    logic loaded_ok_q;
    // Event flag
    logic event_q;
    logic event_d;
    // Decodes and read bytes
    logic net_status_rd;
    logic net_wr_lo;
    logic net_wr_hi;
    logic [7:0] net_rd_byte;
    logic [7:0] host_rd_byte;

    // Every status field as a one-hot mask, so that clashes show up at elaboration
    localparam logic [15:0] STATUS_USED =
        (16'h0001 << lsrw_pkg::COMM_P0_BIT) | (16'h0001 << lsrw_pkg::COMM_P1_BIT)
        | (16'h0001 << lsrw_pkg::COMM_P2_BIT) | (16'h0001 << lsrw_pkg::LOOP_P0_BIT)
        | (16'h0001 << lsrw_pkg::LOOP_P1_BIT) | (16'h0001 << lsrw_pkg::LOOP_P2_BIT)
        | (16'h0001 << lsrw_pkg::LINK_P0_BIT) | (16'h0001 << lsrw_pkg::LINK_P1_BIT)
        | (16'h0001 << lsrw_pkg::LINK_P2_BIT) | (16'h0001 << lsrw_pkg::ENH_LINK_BIT)
        | (16'h0001 << lsrw_pkg::WDOG_BIT) | (16'h0001 << lsrw_pkg::LOADED_BIT);

    // The port vectors are three wide; another port count needs new ports
    if (lsrw_pkg::NUM_PORTS != 3) begin : g_bad_ports
        $error("lsrw_regs serves exactly three ports");
    end
    // Two fields on one bit, or a field past bit 15, would drop a condition silently
    if ($countones(STATUS_USED) != 3 * lsrw_pkg::NUM_PORTS + 3) begin : g_bad_fields
        $error("lsrw_regs status fields overlap or leave the word");
    end
    // Reserved bits and the reset view must read zero
    if (lsrw_pkg::LINK_STATUS_RESET != 16'h0000) begin : g_bad_status_reset
        $error("lsrw_regs status reset value must be zero");
    end
    // A nonzero offset at reset would split datagrams before the master sets it
    if (lsrw_pkg::RW_OFFSET_RESET != 16'h0000) begin : g_bad_offset_reset
        $error("lsrw_regs offset reset value must be zero");
    end
    // Byte pairing and the whole-register read decode assume even base addresses
    if (lsrw_pkg::RW_OFFSET_ADDR[0] != 1'b0) begin : g_bad_offset_base
        $error("lsrw_regs offset register must start at an even address");
    end
    if (lsrw_pkg::LINK_STATUS_ADDR[0] != 1'b0) begin : g_bad_status_base
        $error("lsrw_regs status register must start at an even address");
    end
    // Overlapping registers would let an offset write alias a status read
    if (lsrw_pkg::RW_OFFSET_ADDR[15:1] == lsrw_pkg::LINK_STATUS_ADDR[15:1]) begin : g_overlap
        $error("lsrw_regs registers share an address");
    end
    // The synchroniser below is sized for the live bundle
    if ($bits(lsrw_pkg::lsrw_live_t) != 3 * lsrw_pkg::NUM_PORTS + 1) begin : g_bad_live
        $error("lsrw_regs live bundle width does not match the port count");
    end

    assign live_raw = '{comm: port_comm_i, loop_closed: port_loop_closed_i,
                        link: port_link_i, wdog_ok: wdog_reloaded_i};

    // Port conditions come from outside this clock, so each passes the synchroniser
    lsrw_sync #(
        .WIDTH(10)
    ) u_sync (
        .clk_i(clk_i),
        .reset_i(reset_i),
        .async_i(live_raw),
        .sync_o(live)
    );

    // Byte selection shared by both readers, low byte at the even address
    function automatic logic [7:0] rd_byte(input logic [15:0] addr,
                                           input logic [15:0] offs,
                                           input logic [15:0] stat);
        logic [7:0] r;
        r = 8'h00;
        if (addr == lsrw_pkg::RW_OFFSET_ADDR) begin
            r = offs[7:0];
        end else if (addr == 16'(lsrw_pkg::RW_OFFSET_ADDR + 16'h0001)) begin
            r = offs[15:8];
        end else if (addr == lsrw_pkg::LINK_STATUS_ADDR) begin
            r = stat[7:0];
        end else if (addr == 16'(lsrw_pkg::LINK_STATUS_ADDR + 16'h0001)) begin
            r = stat[15:8];
        end
        return r;
    endfunction

    // Offset write decode: only the network side may write it
    assign net_wr_lo = net_acc_i.wr && (net_acc_i.addr == lsrw_pkg::RW_OFFSET_ADDR);
    assign net_wr_hi = net_acc_i.wr
        && (net_acc_i.addr == 16'(lsrw_pkg::RW_OFFSET_ADDR + 16'h0001));
    assign rw_offset_d = {net_wr_hi ? net_acc_i.wdata : rw_offset_q[15:8],
                          net_wr_lo ? net_acc_i.wdata : rw_offset_q[7:0]};

    // Status word rebuilt every cycle; no write path reaches it
    always_comb begin
        status_d = lsrw_pkg::LINK_STATUS_RESET;
        // Stable communication per port
        status_d[lsrw_pkg::COMM_P0_BIT] = live.comm[0];
        status_d[lsrw_pkg::COMM_P1_BIT] = live.comm[1];
        status_d[lsrw_pkg::COMM_P2_BIT] = live.comm[2];

        // Loop state per port
        status_d[lsrw_pkg::LOOP_P0_BIT] = live.loop_closed[0];
        status_d[lsrw_pkg::LOOP_P1_BIT] = live.loop_closed[1];
        status_d[lsrw_pkg::LOOP_P2_BIT] = live.loop_closed[2];

        // Physical link per port
        status_d[lsrw_pkg::LINK_P0_BIT] = live.link[0];
        status_d[lsrw_pkg::LINK_P1_BIT] = live.link[1];
        status_d[lsrw_pkg::LINK_P2_BIT] = live.link[2];

        // Load, watchdog and enhanced link state
        status_d[lsrw_pkg::ENH_LINK_BIT] = enh_link_q;
        status_d[lsrw_pkg::WDOG_BIT] = live.wdog_ok;
        status_d[lsrw_pkg::LOADED_BIT] = loaded_ok_q;
    end

    // Both readers see the registered status, so a read matches the word on the port
    assign net_rd_byte = rd_byte(net_acc_i.addr, rw_offset_q, link_status_o);
    assign host_rd_byte = rd_byte(host_acc_i.addr, rw_offset_q, link_status_o);

    // Either status byte counts as a read of the whole register
    assign net_status_rd = net_acc_i.rd
        && (net_acc_i.addr[15:1] == lsrw_pkg::LINK_STATUS_ADDR[15:1]);
    // A new event in the same cycle as the clearing read is kept
    assign event_d = link_event_set_i | (event_q & ~net_status_rd);

    // Offset register
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            rw_offset_q <= lsrw_pkg::RW_OFFSET_RESET;
        end else begin
            rw_offset_q <= rw_offset_d;
        end
    end

    // Enhanced link is latched at the first load only; only reset opens it again
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            enh_link_q <= 1'b0;
            first_load_seen_q <= 1'b0;
        end else if (load_done_i && !first_load_seen_q) begin
            enh_link_q <= load_enh_link_i;
            first_load_seen_q <= 1'b1;
        end
    end

    // Load result follows every load, so a failed reload shuts the host data path again
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            loaded_ok_q <= 1'b0;
        end else if (load_done_i) begin
            loaded_ok_q <= load_ok_i;
        end
    end

    // Status view: live levels and load state, rebuilt every clock
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            link_status_o <= lsrw_pkg::LINK_STATUS_RESET;
        end else begin
            link_status_o <= status_d;
        end
    end

    // Event flag; set beats the clearing read so no event is lost
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            event_q <= 1'b0;
        end else begin
            event_q <= event_d;
        end
    end

    // Network read answer; zero when idle so a stale byte never lingers
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            net_rdata_o <= 8'h00;
            net_rvalid_o <= 1'b0;
        end else begin
            net_rdata_o <= net_acc_i.rd ? net_rd_byte : 8'h00;
            net_rvalid_o <= net_acc_i.rd;
        end
    end

    // Host read answer; the host may read both registers but write neither
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            host_rdata_o <= 8'h00;
            host_rvalid_o <= 1'b0;
        end else begin
            host_rdata_o <= host_acc_i.rd ? host_rd_byte : 8'h00;
            host_rvalid_o <= host_acc_i.rd;
        end
    end

    // Flag copy so the output leaves a flop; it equals the flag after the edge
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            link_event_o <= 1'b0;
        end else begin
            link_event_o <= event_d;
        end
    end

    // Host data gate lines up with status bit 0, both one clock after the load state
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            host_pd_enable_o <= 1'b0;
        end else begin
            host_pd_enable_o <= loaded_ok_q;
        end
    end

    // Offset view copy, fed from the same next value as the register itself
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            rw_offset_o <= lsrw_pkg::RW_OFFSET_RESET;
        end else begin
            rw_offset_o <= rw_offset_d;
        end
    end

    // Address split: the read address is the datagram address, write adds the offset
    lsrw_addr_adder u_adder (
        .clk_i(clk_i),
        .reset_i(reset_i),
        .valid_i(rw_dgram_valid_i),
        .addr_i(rw_dgram_addr_i),
        .offset_i(rw_offset_q),
        .valid_o(rw_dgram_valid_o),
        .rd_addr_o(rw_dgram_rd_addr_o),
        .wr_addr_o(rw_dgram_wr_addr_o)
    );
endmodule // lsrw_regs

// >>> rtl/lsrw_sync.sv
// Three-stage synchroniser that accepts a change once stages two and three agree
`timescale 1ns/100ps
module lsrw_sync #(
    parameter int WIDTH = 1
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic reset_i,
    // Data
    input wire logic [WIDTH-1:0] async_i,
    output logic [WIDTH-1:0] sync_o
);
    logic [WIDTH-1:0] s1_q;
    logic [WIDTH-1:0] s2_q;
    logic [WIDTH-1:0] s3_q;
    logic [WIDTH-1:0] agree;

    // A zero-width bank has nothing to carry
    if (WIDTH < 1) begin : g_bad_width
        $error("lsrw_sync needs a width of at least one");
    end

    // Only stage two reads stage one, which keeps the metastable flop isolated
    assign agree = ~(s2_q ^ s3_q);

    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            s1_q <= '0;
            s2_q <= '0;
            s3_q <= '0;
            sync_o <= '0;
        end else begin
            s1_q <= async_i;
            s2_q <= s1_q;
            s3_q <= s2_q;
            sync_o <= (agree & s3_q) | (~agree & sync_o);
        end
    end
endmodule // lsrw_sync

// >>> verif/link_status_and_rw_offset_test.sv
// Self-checking bench for the link status and read-write offset bank
`timescale 1ns/100ps
module link_status_and_rw_offset_test;
    logic clk_i = 1'b0;
    logic reset_i = 1'b1;
    lsrw_pkg::lsrw_acc_t net_acc_i = '0;
    lsrw_pkg::lsrw_acc_t host_acc_i = '0;
    logic [2:0] port_comm_i = 3'h0;
    logic [2:0] port_loop_closed_i = 3'h0;
    logic [2:0] port_link_i = 3'h0;
    logic wdog_reloaded_i = 1'b0;
    logic link_event_set_i = 1'b0;
    logic rw_dgram_valid_i = 1'b0;
    logic [15:0] rw_dgram_addr_i = 16'h0000;
    logic load = 1'b0;
    logic ok = 1'b0;
    logic enh = 1'b0;
    logic load_done_i, load_ok_i, load_enh_link_i, net_rvalid_o, host_rvalid_o;
    logic link_event_o, host_pd_enable_o, rw_dgram_valid_o;
    logic [7:0] net_rdata_o, host_rdata_o, q;
    logic [15:0] rw_dgram_rd_addr_o, rw_dgram_wr_addr_o, rw_offset_o, link_status_o;
    logic [15:0] ld_bits = 16'h0000;
    int err_total = 0;
    int tests_run = 0;
    always #5 clk_i = ~clk_i;
    lsrw_far_model u_lsrw_far_model (.load_i(load), .ok_i(ok), .enh_i(enh),
        .done_o(load_done_i), .ok_o(load_ok_i), .enh_o(load_enh_link_i));
    lsrw_regs u_lsrw_regs (.clk_i, .reset_i, .net_acc_i, .net_rdata_o, .net_rvalid_o,
        .host_acc_i, .host_rdata_o, .host_rvalid_o, .port_comm_i, .port_loop_closed_i,
        .port_link_i, .wdog_reloaded_i, .load_done_i, .load_ok_i, .load_enh_link_i,
        .link_event_set_i, .link_event_o, .host_pd_enable_o, .rw_dgram_valid_i,
        .rw_dgram_addr_i, .rw_dgram_valid_o, .rw_dgram_rd_addr_o, .rw_dgram_wr_addr_o,
        .rw_offset_o, .link_status_o);
    task automatic end_of_test;
        if (err_total == 0 && tests_run > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        tests_run++;
        if (seen !== exp) begin
            err_total++;
            $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
        end
    endtask
    // One byte access held for one edge; read data lands one edge later
    task automatic bus(input logic host, input logic rd, input logic [15:0] a,
                       input logic [7:0] d);
        @(posedge clk_i);
        #1;
        if (host) host_acc_i = '{rd, !rd, a, d};
        else net_acc_i = '{rd, !rd, a, d};
        @(posedge clk_i);
        #1;
        net_acc_i = '0;
        host_acc_i = '0;
        q = host ? host_rdata_o : net_rdata_o;
        if (rd) chk(host ? host_rvalid_o : net_rvalid_o, 1'b1);
    endtask
    // Bytes written apart, refused writes, read back and an unmapped read
    task automatic t_offset;
        bus(0, 0, lsrw_pkg::RW_OFFSET_ADDR, 8'h34);
        bus(0, 0, lsrw_pkg::RW_OFFSET_ADDR + 16'h0001, 8'h12);
        bus(1, 0, lsrw_pkg::RW_OFFSET_ADDR, 8'hFF);
        bus(0, 0, lsrw_pkg::LINK_STATUS_ADDR, 8'hFF);
        chk(rw_offset_o, 16'h1234);
        bus(1, 1, lsrw_pkg::RW_OFFSET_ADDR + 16'h0001, 8'h00);
        chk(q, 8'h12);
        bus(0, 1, 16'h010A, 8'h00);
        chk(q, 8'h00);
    endtask
    // Split that wraps past the top of the address space
    task automatic t_dgram;
        @(posedge clk_i);
        #1;
        rw_dgram_valid_i = 1'b1;
        rw_dgram_addr_i = 16'hFFF0;
        @(posedge clk_i);
        #1;
        rw_dgram_valid_i = 1'b0;
        chk(rw_dgram_valid_o, 1'b1);
        chk(rw_dgram_rd_addr_o, 16'hFFF0);
        chk(rw_dgram_wr_addr_o, 16'h1224);
    endtask
    // Live levels land in their status bits and read back high byte first
    task automatic t_status(input logic [2:0] c, input logic [2:0] l, input logic [2:0] k,
                            input logic w);
        logic [15:0] e;
        e = ld_bits;
        for (int n = 0; n < lsrw_pkg::NUM_PORTS; n++) begin
            e[lsrw_pkg::COMM_P0_BIT + 2 * n] = c[n];
            e[lsrw_pkg::LOOP_P0_BIT + 2 * n] = l[n];
            e[lsrw_pkg::LINK_P0_BIT + n] = k[n];
        end
        e[lsrw_pkg::WDOG_BIT] = w;
        @(posedge clk_i);
        #1;
        {port_comm_i, port_loop_closed_i, port_link_i, wdog_reloaded_i} = {c, l, k, w};
        repeat (8) @(posedge clk_i);
        #1;
        chk(link_status_o, e);
        bus(0, 1, lsrw_pkg::LINK_STATUS_ADDR + 16'h0001, 8'h00);
        chk(q, e[15:8]);
        bus(0, 1, lsrw_pkg::LINK_STATUS_ADDR, 8'h00);
        chk(q, e[7:0]);
    endtask
    // Event flag set, then cleared by a network read of the status high byte
    task automatic t_event;
        @(posedge clk_i);
        #1;
        link_event_set_i = 1'b1;
        @(posedge clk_i);
        #1;
        link_event_set_i = 1'b0;
        chk(link_event_o, 1'b1);
        bus(0, 1, lsrw_pkg::LINK_STATUS_ADDR + 16'h0001, 8'h00);
        chk(link_event_o, 1'b0);
    endtask
    // One load pulse; the enhanced bit must only follow the first one
    task automatic t_load(input logic k, input logic x, input logic [15:0] want);
        @(posedge clk_i);
        #1;
        {load, ok, enh} = {1'b1, k, x};
        @(posedge clk_i);
        #1;
        load = 1'b0;
        repeat (3) @(posedge clk_i);
        #1;
        ld_bits = want;
        chk(link_status_o & 16'h0005, want);
        chk(host_pd_enable_o, want[0]);
    endtask
    // Main sequence after six cycles of reset
    initial begin
        repeat (6) @(posedge clk_i);
        #1;
        reset_i = 1'b0;
        chk(link_status_o, lsrw_pkg::LINK_STATUS_RESET);
        chk(host_pd_enable_o, 1'b0);
        t_offset;
        t_dgram;
        t_status(3'b101, 3'b011, 3'b110, 1'b1);
        t_load(1'b1, 1'b1, 16'h0005);
        t_status(3'b010, 3'b100, 3'b001, 1'b0);
        t_load(1'b0, 1'b0, 16'h0004);
        t_event;
        end_of_test;
    end
    // Hang guard
    initial begin
        #100000;
        err_total++;
        end_of_test;
    end
endmodule // link_status_and_rw_offset_test
bind lsrw_regs lsrw_props u_lsrw_props (.clk_i, .reset_i, .net_acc_i, .port_link_i,
    .load_done_i, .load_ok_i, .link_event_set_i, .rw_dgram_valid_i, .rw_dgram_addr_i,
    .link_event_o, .host_pd_enable_o, .rw_dgram_valid_o, .rw_dgram_rd_addr_o,
    .rw_dgram_wr_addr_o, .rw_offset_o, .link_status_o);

// >>> verif/lsrw_far_model.sv
// Behavioural configuration memory loader on the far side of the bank
`timescale 1ns/100ps
module lsrw_far_model (
    // Requests from the bench
    input wire logic load_i,
    input wire logic ok_i,
    input wire logic enh_i,
    // Lines into the bank
    output logic done_o,
    output logic ok_o,
    output logic enh_o
);
    // Result lines are only valid beside the pulse, so scramble them elsewhere
    assign done_o = load_i;
    assign ok_o = load_i ? ok_i : ~ok_i;
    assign enh_o = load_i ? enh_i : ~enh_i;
endmodule // lsrw_far_model

// >>> verif/lsrw_props.sv
// Concurrent checks on the ports of the link status and offset bank
`timescale 1ns/100ps
module lsrw_props (
    // Clock and reset
    input wire logic clk_i,
    input wire logic reset_i,
    // Inputs watched
    input wire lsrw_pkg::lsrw_acc_t net_acc_i,
    input wire logic [2:0] port_link_i,
    input wire logic load_done_i,
    input wire logic load_ok_i,
    input wire logic link_event_set_i,
    input wire logic rw_dgram_valid_i,
    input wire logic [15:0] rw_dgram_addr_i,
    // Outputs watched
    input wire logic link_event_o,
    input wire logic host_pd_enable_o,
    input wire logic rw_dgram_valid_o,
    input wire logic [15:0] rw_dgram_rd_addr_o,
    input wire logic [15:0] rw_dgram_wr_addr_o,
    input wire logic [15:0] rw_offset_o,
    input wire logic [15:0] link_status_o
);
    default clocking @(posedge clk_i);
    endclocking
    default disable iff (reset_i);
    // Link levels quiet long enough to clear the synchroniser and output flop
    sequence s_quiet;
        $stable(port_link_i) [*7];
    endsequence
    sequence s_net_status_rd;
        net_acc_i.rd && net_acc_i.addr[15:1] == 15'h0088 && !link_event_set_i;
    endsequence
    property p_live; s_quiet |-> link_status_o[6:4] == port_link_i; endproperty
    a_live: assert property (p_live) else $error("link bits lag the port");
    property p_split; rw_dgram_valid_i |=> rw_dgram_valid_o
        && rw_dgram_rd_addr_o == $past(rw_dgram_addr_i)
        && rw_dgram_wr_addr_o == $past(rw_dgram_addr_i) + $past(rw_offset_o); endproperty
    a_split: assert property (p_split) else $error("datagram address split wrong");
    property p_offs; net_acc_i.wr && net_acc_i.addr == 16'h0108
        |=> rw_offset_o[7:0] == $past(net_acc_i.wdata); endproperty
    a_offs: assert property (p_offs) else $error("offset low byte not written");
    property p_ev_set; link_event_set_i |=> link_event_o; endproperty
    a_ev_set: assert property (p_ev_set) else $error("event flag not set");
    property p_ev_clr; s_net_status_rd |=> !link_event_o; endproperty
    a_ev_clr: assert property (p_ev_clr) else $error("status read kept flag");
    property p_load; load_done_i |-> ##2 link_status_o[0] == $past(load_ok_i, 2); endproperty
    a_load: assert property (p_load) else $error("loaded bit wrong");
    property p_enh; $changed(link_status_o[2]) |-> $past(load_done_i, 2); endproperty
    a_enh: assert property (p_enh) else $error("enhanced bit moved without load");
    property p_pd; !link_status_o[0] && !$past(link_status_o[0]) |-> !host_pd_enable_o;
    endproperty
    a_pd: assert property (p_pd) else $error("host data open before load");
endmodule // lsrw_props
